// *** sram_port_pkg.sv ***
// ****************************************************************
// widths, reset values and timing of the burst-of-two port
// ****************************************************************
package sram_port_pkg;

   // ************************************************************
   // bus and array shape
   // ************************************************************
   localparam int DATA_W  = 36;          // one data word
   localparam int LANE_W  = 9;           // one byte lane
   localparam int LANES   = 4;           // byte lanes per word
   localparam int UPPER_W = 18;          // address above the burst bit
   localparam int BEATS   = 2;           // words per command
   localparam int PAIR_W  = DATA_W * BEATS;
   localparam int PAIR_EN = LANES * BEATS;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [DATA_W-1:0]  DATA_RST = 36'h000000000;
   localparam logic [UPPER_W-1:0] ADDR_RST = 18'h00000;
   localparam logic [LANES-1:0]   MASK_RST = 4'hf;
   localparam logic [PAIR_W-1:0]  PAIR_RST = 72'h000000000000000000;
   localparam logic [PAIR_EN-1:0] EN_RST   = 8'h00;

   // ************************************************************
   // timing counts
   // ************************************************************
   localparam int              DLL_LOCK_CYCLES = 1024;   // clocks after enable
   localparam int              DLL_CNT_W       = 11;
   localparam logic [10:0]     DLL_CNT_RST     = 11'h000;
   localparam logic [10:0]     DLL_CNT_LAST    = 11'(DLL_LOCK_CYCLES - 1);
   localparam int              STRAP_CNT_W     = 2;
   localparam logic [1:0]      STRAP_CNT_RST   = 2'h0;
   localparam logic [1:0]      STRAP_CNT_LAST  = 2'h2;  // third edge after release

   // ************************************************************
   // command held in the first pipeline stage
   // ************************************************************
   typedef enum logic [1:0] {
      OP_IDLE,
      OP_READ,
      OP_WRITE
   } op_e;

endpackage : sram_port_pkg

// *** sram_store.sv ***
`timescale 1ns/1ps
// ****************************************************************
// storage array: one pair of words per entry, lane write enables
// ****************************************************************
module sram_store (
   // clock
   input  wire logic                               clock_i,
   // write port
   input  wire logic                               we_i,
   input  wire logic [sram_port_pkg::PAIR_EN-1:0]  wen_i,
   input  wire logic [sram_port_pkg::UPPER_W-1:0]  waddr_i,
   input  wire logic [sram_port_pkg::PAIR_W-1:0]   wdata_i,
   // read port
   input  wire logic                               re_i,
   input  wire logic [sram_port_pkg::UPPER_W-1:0]  raddr_i,
   output logic      [sram_port_pkg::PAIR_W-1:0]   rdata_o
);

   localparam int DEPTH = 1 << sram_port_pkg::UPPER_W;
   localparam int LW    = sram_port_pkg::LANE_W;

   logic [sram_port_pkg::PAIR_W-1:0] mem [DEPTH];

   // one lane slice per generate step, so masked lanes keep old data
   genvar g;
   generate
      for (g = 0; g < sram_port_pkg::PAIR_EN; g++) begin : g_lane
         always_ff @(posedge clock_i) begin
            if (we_i && wen_i[g]) begin
               mem[waddr_i][g*LW +: LW] <= wdata_i[g*LW +: LW];
            end
         end
      end
   endgenerate

   // registered read: old contents on a same-edge write
   always_ff @(posedge clock_i) begin
      if (re_i) begin
         rdata_o <= mem[raddr_i];
      end
   end

endmodule : sram_store

// *** ddr_burst2_sram_port.sv ***
`timescale 1ns/1ps
// Contract
// - cycle starts only with load_n low
// - read high captures address on K
// - read address has its own register
// - every command moves exactly two words
// - read beat0 on C#, beat1 on C
// - back-to-back reads stream every half cycle; the code does this only in single clock mode, C pair mode needs spaced reads
// - C pair high: launch from K
// - burst finishes, then drivers go off
// - write low, address into write register
// - write beats on next K, then K#
// - back-to-back writes accepted every edge
// - deselect ignores data in that cycle
// - each byte_write_n gates one lane
// - single clock mode fixed at power up
// - pending work completes before deselect
// - dll_off_n low disables the loop
// - burst_start_bit orders the two words
// - linear order: 0 then 1, 1 then 0
// - stopped clock: pending done, outputs hold
module ddr_burst2_sram_port (
   // main clock K and reset
   input  wire logic                               clock_i,
   input  wire logic                               rst_i,
   // output clock pair C, link domain
   input  wire logic                               out_clk_i,
   input  wire logic                               out_clk_n_i,
   // command and address
   input  wire logic                               load_n_i,
   input  wire logic                               read_write_sel_i,
   input  wire logic [sram_port_pkg::UPPER_W-1:0]  upper_address_i,
   input  wire logic                               burst_start_bit_i,
   input  wire logic [sram_port_pkg::LANES-1:0]    byte_write_n_i,
   input  wire logic                               dll_off_n_i,
   // shared data bus
   input  wire logic [sram_port_pkg::DATA_W-1:0]   shared_data_bus_i,
   output logic      [sram_port_pkg::DATA_W-1:0]   shared_data_bus_o,
   output logic                                    shared_data_bus_oe_o,
   // status
   output logic                                    dll_locked_o,
   output logic                                    single_clock_mode_o
);

   localparam int DW = sram_port_pkg::DATA_W;
   localparam int LW = sram_port_pkg::LANE_W;

   // ************************************************************
   // lane and word helpers
   // ************************************************************

   // offset 0 sits in the low half of a stored pair
   function automatic logic [sram_port_pkg::PAIR_W-1:0] place_pair(
      input logic [DW-1:0] b0,
      input logic [DW-1:0] b1,
      input logic          s);
      place_pair = s ? {b0, b1} : {b1, b0};
   endfunction : place_pair

   // lane enables follow the same placement as the data
   function automatic logic [sram_port_pkg::PAIR_EN-1:0] place_en(
      input logic [sram_port_pkg::LANES-1:0] m0_n,
      input logic [sram_port_pkg::LANES-1:0] m1_n,
      input logic                            s);
      place_en = s ? {~m0_n, ~m1_n} : {~m1_n, ~m0_n};
   endfunction : place_en

   // overlay enabled lanes of a fresh write onto old contents
   function automatic logic [sram_port_pkg::PAIR_W-1:0] lane_merge(
      input logic [sram_port_pkg::PAIR_W-1:0]  old_w,
      input logic [sram_port_pkg::PAIR_W-1:0]  new_w,
      input logic [sram_port_pkg::PAIR_EN-1:0] en);
      logic [sram_port_pkg::PAIR_W-1:0] r;
      r = old_w;
      for (int i = 0; i < sram_port_pkg::PAIR_EN; i++) begin
         if (en[i]) begin
            r[i*LW +: LW] = new_w[i*LW +: LW];
         end
      end
      lane_merge = r;
   endfunction : lane_merge

   // ************************************************************
   // declarations
   // ************************************************************
   sram_port_pkg::op_e                 cmd_op_q;
   logic [sram_port_pkg::UPPER_W-1:0]  rd_addr_q;
   logic                               rd_start_q;
   logic [sram_port_pkg::UPPER_W-1:0]  pend_addr_q;
   logic                               pend_start_q;
   logic [sram_port_pkg::UPPER_W-1:0]  wr_addr_q;
   logic                               wr_start_q;
   logic                               wr_arm_q;
   logic [DW-1:0]                      beat0_q;
   logic [DW-1:0]                      beat1_q;
   logic [sram_port_pkg::LANES-1:0]    mask0_n_q;
   logic [sram_port_pkg::LANES-1:0]    mask1_n_q;
   logic [sram_port_pkg::PAIR_W-1:0]   wr_pair;
   logic [sram_port_pkg::PAIR_EN-1:0]  wr_en;
   logic                               mem_re;
   logic [sram_port_pkg::PAIR_W-1:0]   mem_rdata;
   logic                               rd_go_q;
   logic                               rd_go_start_q;
   logic [sram_port_pkg::PAIR_EN-1:0]  byp_en_q;
   logic [sram_port_pkg::PAIR_W-1:0]   byp_data_q;
   logic [sram_port_pkg::PAIR_W-1:0]   rd_pair;
   logic [DW-1:0]                      kn_data_q;
   logic [DW-1:0]                      kn_second_q;
   logic                               kn_oe_q;
   logic [DW-1:0]                      kp_data_q;
   logic                               kp_oe_q;
   logic [DW-1:0]                      xfer_first_q;
   logic [DW-1:0]                      xfer_second_q;
   logic                               rd_tgl_q;
   logic [2:0]                         c_tgl_q;
   logic                               c_go_q;
   logic [DW-1:0]                      cn_data_q;
   logic                               cn_oe_q;
   logic [DW-1:0]                      cp_data_q;
   logic                               cp_oe_q;
   logic [1:0]                         strap_p_q;
   logic [1:0]                         strap_n_q;
   logic [sram_port_pkg::STRAP_CNT_W-1:0] strap_cnt_q;
   logic                               strap_done_q;
   logic                               single_q;
   logic [1:0]                         dll_en_q;
   logic [sram_port_pkg::DLL_CNT_W-1:0] dll_cnt_q;
   logic                               dll_locked_q;

   // ************************************************************
   // command stage on K
   // ************************************************************

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_op_q <= sram_port_pkg::OP_IDLE;
      end else if (load_n_i) begin
         cmd_op_q <= sram_port_pkg::OP_IDLE;
      end else begin
         cmd_op_q <= read_write_sel_i ? sram_port_pkg::OP_READ : sram_port_pkg::OP_WRITE;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rd_addr_q  <= sram_port_pkg::ADDR_RST;
         rd_start_q <= 1'b0;
      end else if (!load_n_i && read_write_sel_i) begin
         rd_addr_q  <= upper_address_i;
         rd_start_q <= burst_start_bit_i;
      end
   end

   // staging for the write address, which lands one K later
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pend_addr_q  <= sram_port_pkg::ADDR_RST;
         pend_start_q <= 1'b0;
      end else if (!load_n_i && !read_write_sel_i) begin
         pend_addr_q  <= upper_address_i;
         pend_start_q <= burst_start_bit_i;
      end
   end

   // ************************************************************
   // late write path
   // ************************************************************

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wr_addr_q  <= sram_port_pkg::ADDR_RST;
         wr_start_q <= 1'b0;
         wr_arm_q   <= 1'b0;
      end else begin
         wr_arm_q <= (cmd_op_q == sram_port_pkg::OP_WRITE);
         if (cmd_op_q == sram_port_pkg::OP_WRITE) begin
            wr_addr_q  <= pend_addr_q;
            wr_start_q <= pend_start_q;
         end
      end
   end

   // deselect data dropped
   // data seen without a write in flight is dropped
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         beat0_q   <= sram_port_pkg::DATA_RST;
         mask0_n_q <= sram_port_pkg::MASK_RST;
      end else if (cmd_op_q == sram_port_pkg::OP_WRITE) begin
         beat0_q   <= shared_data_bus_i;
         mask0_n_q <= byte_write_n_i;
      end
   end

   // second beat own mask
   // K# rising is taken as the falling edge of K
   always_ff @(negedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         beat1_q   <= sram_port_pkg::DATA_RST;
         mask1_n_q <= sram_port_pkg::MASK_RST;
      end else if (wr_arm_q) begin
         beat1_q   <= shared_data_bus_i;
         mask1_n_q <= byte_write_n_i;
      end
   end

   assign wr_pair = place_pair(beat0_q, beat1_q, wr_start_q);
   assign wr_en   = place_en(mask0_n_q, mask1_n_q, wr_start_q);
   assign mem_re  = (cmd_op_q == sram_port_pkg::OP_READ);

   sram_store u_store (
      .clock_i (clock_i),
      .we_i    (wr_arm_q),
      .wen_i   (wr_en),
      .waddr_i (wr_addr_q),
      .wdata_i (wr_pair),
      .re_i    (mem_re),
      .raddr_i (rd_addr_q),
      .rdata_o (mem_rdata)
   );

   // ************************************************************
   // read path on K
   // ************************************************************

   // a write committing on the read edge is merged in, so reads see newest data
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rd_go_q       <= 1'b0;
         rd_go_start_q <= 1'b0;
         byp_en_q      <= sram_port_pkg::EN_RST;
         byp_data_q    <= sram_port_pkg::PAIR_RST;
      end else begin
         rd_go_q       <= mem_re;
         rd_go_start_q <= rd_start_q;
         byp_data_q    <= wr_pair;
         byp_en_q      <= (mem_re && wr_arm_q && wr_addr_q == rd_addr_q) ?
                          wr_en : sram_port_pkg::EN_RST;
      end
   end

   assign rd_pair = lane_merge(mem_rdata, byp_data_q, byp_en_q);

   always_ff @(negedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         kn_data_q     <= sram_port_pkg::DATA_RST;
         kn_second_q   <= sram_port_pkg::DATA_RST;
         kn_oe_q       <= 1'b0;
         xfer_first_q  <= sram_port_pkg::DATA_RST;
         xfer_second_q <= sram_port_pkg::DATA_RST;
         rd_tgl_q      <= 1'b0;
      end else begin
         kn_oe_q <= rd_go_q;
         if (rd_go_q) begin
            kn_data_q     <= rd_go_start_q ? rd_pair[2*DW-1:DW] : rd_pair[DW-1:0];
            kn_second_q   <= rd_go_start_q ? rd_pair[DW-1:0] : rd_pair[2*DW-1:DW];
            xfer_first_q  <= rd_go_start_q ? rd_pair[2*DW-1:DW] : rd_pair[DW-1:0];
            xfer_second_q <= rd_go_start_q ? rd_pair[DW-1:0] : rd_pair[2*DW-1:DW];
            rd_tgl_q      <= ~rd_tgl_q;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         kp_data_q <= sram_port_pkg::DATA_RST;
         kp_oe_q   <= 1'b0;
      end else begin
         kp_oe_q <= kn_oe_q;
         if (kn_oe_q) begin
            kp_data_q <= kn_second_q;
         end
      end
   end

   // ************************************************************
   // read launch on the output clock pair
   // ************************************************************

   // toggle crossing; the word pair stays put until the next read
   always_ff @(posedge out_clk_i or posedge rst_i) begin
      if (rst_i) begin
         c_tgl_q <= 3'h0;
         c_go_q  <= 1'b0;
      end else begin
         c_tgl_q <= {c_tgl_q[1:0], rd_tgl_q};
         c_go_q  <= c_tgl_q[2] ^ c_tgl_q[1];
      end
   end

   always_ff @(negedge out_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cn_data_q <= sram_port_pkg::DATA_RST;
         cn_oe_q   <= 1'b0;
      end else begin
         cn_oe_q <= c_go_q;
         if (c_go_q) begin
            cn_data_q <= xfer_first_q;
         end
      end
   end

   always_ff @(posedge out_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cp_data_q <= sram_port_pkg::DATA_RST;
         cp_oe_q   <= 1'b0;
      end else begin
         cp_oe_q <= cn_oe_q;
         if (cn_oe_q) begin
            cp_data_q <= xfer_second_q;
         end
      end
   end

   // ************************************************************
   // clock mode strap and delay loop
   // ************************************************************

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         strap_p_q    <= 2'h0;
         strap_n_q    <= 2'h0;
         strap_cnt_q  <= sram_port_pkg::STRAP_CNT_RST;
         strap_done_q <= 1'b0;
         single_q     <= 1'b0;
      end else begin
         strap_p_q <= {strap_p_q[0], out_clk_i};
         strap_n_q <= {strap_n_q[0], out_clk_n_i};
         if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == sram_port_pkg::STRAP_CNT_LAST) begin
               strap_done_q <= 1'b1;
               single_q     <= strap_p_q[1] & strap_n_q[1];
            end
         end
      end
   end

   // loop off when low
   // lock is only modelled as a count; there is no analog loop here
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         dll_en_q     <= 2'h0;
         dll_cnt_q    <= sram_port_pkg::DLL_CNT_RST;
         dll_locked_q <= 1'b0;
      end else begin
         dll_en_q <= {dll_en_q[0], dll_off_n_i};
         if (!dll_en_q[1]) begin
            dll_cnt_q    <= sram_port_pkg::DLL_CNT_RST;
            dll_locked_q <= 1'b0;
         end else if (!dll_locked_q) begin
            dll_cnt_q <= dll_cnt_q + 11'h001;
            if (dll_cnt_q == sram_port_pkg::DLL_CNT_LAST) begin
               dll_locked_q <= 1'b1;
            end
         end
      end
   end

   // ************************************************************
   // pads
   // ************************************************************

   // single mode uses K
   // double-rate select by clock level, as an output DDR cell does
   assign shared_data_bus_o    = single_q ? (clock_i ? kp_data_q : kn_data_q) :
                                            (out_clk_i ? cp_data_q : cn_data_q);
   assign shared_data_bus_oe_o = single_q ? (clock_i ? kp_oe_q : kn_oe_q) :
                                            (out_clk_i ? cp_oe_q : cn_oe_q);
   assign dll_locked_o         = dll_locked_q;
   assign single_clock_mode_o  = single_q;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_read_cmd;
      !load_n_i && read_write_sel_i;
   endsequence

   sequence s_write_cmd;
      !load_n_i && !read_write_sel_i;
   endsequence

   chk_idle_no_drive: assert property (load_n_i |-> ##3 !kp_oe_q)
      else $error("driver enabled for an idle cycle");
   chk_read_addr_reg: assert property (s_read_cmd |=>
                                       rd_addr_q == $past(upper_address_i))
      else $error("read address not captured");
   chk_read_latency: assert property (s_read_cmd |-> ##2 rd_go_q ##1 kp_oe_q)
      else $error("read burst not launched on time");
   chk_burst_end: assert property (s_read_cmd ##1 load_n_i |-> ##3 !kp_oe_q)
      else $error("driver left on after burst");
   chk_write_addr_reg: assert property (s_write_cmd |-> ##2
                                        wr_addr_q == $past(upper_address_i, 2))
      else $error("write address not registered");
   chk_write_commit: assert property (s_write_cmd |-> ##2 wr_arm_q)
      else $error("write not committed");
   chk_deselect_ignore: assert property (load_n_i |-> ##2 !wr_arm_q)
      else $error("data taken in deselect");
   chk_strap_frozen: assert property (strap_done_q |=> $stable(single_q))
      else $error("clock mode changed after power up");
   chk_dll_off: assert property (!dll_en_q[1] |=> !dll_locked_q)
      else $error("loop locked while disabled");
   chk_c_launch: assert property (@(posedge out_clk_i) disable iff (rst_i)
                                  c_go_q |=> cp_oe_q)
      else $error("second beat missing on output clock");

endmodule : ddr_burst2_sram_port

// *** host_bus.sv ***
`timescale 1ns/1ps
// ***************************************************
// host controller side of the shared data bus
// ***************************************************
module host_bus (
   // write beat from the host sequencer
   input  wire logic                             drive_i,
   input  wire logic [sram_port_pkg::DATA_W-1:0] beat_i,
   input  wire logic [sram_port_pkg::LANES-1:0]  mask_n_i,
   // pins towards the device
   output logic      [sram_port_pkg::DATA_W-1:0] data_o,
   output logic      [sram_port_pkg::LANES-1:0]  mask_n_o
);
   // drive only write beats
   // a released bus shows the inverse of the last beat, never a stale copy
   always_comb begin
      data_o   = drive_i ? beat_i : ~beat_i;
      mask_n_o = drive_i ? mask_n_i : ~mask_n_i;
   end
endmodule : host_bus

// *** tb.sv ***
`timescale 1ns/1ps
// ***************************************************
// random traffic bench, single clock mode then C pair mode
// ***************************************************
module tb;
   typedef struct {int op; logic [35:0] d0, d1, e0, e1; logic [3:0] m0, m1;} cmd_s;
   logic        clock_i = 1'b0, rst_i = 1'b1, load_n = 1'b1, rw = 1'b0, bsb = 1'b0;
   logic        dll_off_n = 1'b0, drv = 1'b0;
   logic        c_run = 1'b0, c_clk = 1'b1;
   wire         c_clk_n;
   logic [17:0] addr = 18'h00000;
   logic [35:0] beat = 36'h000000000;
   logic [3:0]  msk = 4'hf;
   wire  [35:0] bus_i, bus_o;
   wire  [3:0]  bw_n;
   wire         oe, locked, single;
   int          mismatches = 0, n_compared = 0;
   logic [31:0] rs = 32'h00000001;
   logic [71:0] mem [8];
   cmd_s        h [4];

   // the C pair is parked high for the single clock run, then runs for the C run
   ddr_burst2_sram_port dut_u (.clock_i(clock_i), .rst_i(rst_i), .out_clk_i(c_clk),
      .out_clk_n_i(c_clk_n), .load_n_i(load_n), .read_write_sel_i(rw),
      .upper_address_i(addr), .burst_start_bit_i(bsb), .byte_write_n_i(bw_n),
      .dll_off_n_i(dll_off_n), .shared_data_bus_i(bus_i), .shared_data_bus_o(bus_o),
      .shared_data_bus_oe_o(oe), .dll_locked_o(locked), .single_clock_mode_o(single));
   host_bus host_u (.drive_i(drv), .beat_i(beat), .mask_n_i(msk), .data_o(bus_i),
      .mask_n_o(bw_n));

   initial begin
      forever #5 clock_i = ~clock_i;
   end

   // link clock, offset so its edges never meet a K edge
   initial begin
      #3.3;
      forever #62.5 c_clk = c_run ? ~c_clk : 1'b1;
   end
   assign c_clk_n = c_run ? ~c_clk : 1'b1;

   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : xs

   function automatic logic [71:0] merge(logic [71:0] o, logic f, logic [35:0] d,
                                         logic [3:0] m);
      logic [71:0] r;
      r = o;
      for (int l = 0; l < 4; l++) if (!m[l]) r[f*36+l*9 +: 9] = d[l*9 +: 9];
      return r;
   endfunction : merge

   task automatic chk(logic [35:0] seen, logic [35:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results

   // one K cycle: command, write beats of older commands, read beat checks
   task automatic step(int op, logic [2:0] a, logic b, logic [35:0] x0, logic [35:0] x1,
                       logic [3:0] k0, logic [3:0] k1);
      cmd_s c;
      c = '{op, x0, x1, 36'h0, 36'h0, k0, k1};
      if (op == 1) begin
         c.e0 = mem[a][b*36 +: 36];
         c.e1 = mem[a][(!b)*36 +: 36];
      end
      if (op == 2) mem[a] = merge(merge(mem[a], b, x0, k0), !b, x1, k1);
      for (int i = 3; i > 0; i--) h[i] = h[i-1];
      h[0] = c;
      @(posedge clock_i);
      #1;
      load_n = (op == 0);
      rw = (op == 1) | x0[0] & (op == 0);
      addr = {15'h0000, a};
      bsb = b;
      drv = (h[2].op == 2);
      if (drv) {beat, msk} = {h[2].d1, h[2].m1};
      #2;
      chk(36'(oe), 36'(h[3].op == 1));
      if (h[3].op == 1) chk(bus_o, h[3].e1);
      #3;
      drv = (h[1].op == 2);
      if (drv) {beat, msk} = {h[1].d0, h[1].m0};
      #1;
      chk(36'(oe), 36'(h[2].op == 1));
      if (h[2].op == 1) chk(bus_o, h[2].e0);
   endtask : step

   // one read in C mode: beat0 while C low, beat1 after the next C rise
   task automatic c_read(logic [2:0] a, logic b);
      logic [35:0] e0, e1;
      e0 = mem[a][b*36 +: 36];
      e1 = mem[a][(!b)*36 +: 36];
      @(posedge clock_i);
      #1;
      load_n = 1'b0;
      rw = 1'b1;
      addr = {15'h0000, a};
      bsb = b;
      @(posedge clock_i);
      #1;
      load_n = 1'b1;
      @(posedge oe);
      #1;
      chk(bus_o, e0);
      @(posedge c_clk);
      #1;
      chk(bus_o, e1);
      chk(36'(oe), 36'h1);
      @(negedge c_clk);
      #1;
      chk(36'(oe), 36'h0);
      // spacing keeps the crossed word pair steady for the slow C domain
      repeat (40) @(posedge clock_i);
   endtask : c_read

   initial begin
      #40us;
      mismatches++;
      results();
   end

   initial begin
      int op;
      for (int i = 0; i < 4; i++) h[i].op = 0;
      repeat (20) @(posedge clock_i);
      chk(36'(oe), 36'h0);
      #1 rst_i = 1'b0;
      repeat (4) step(0, 3'h0, 1'b0, 36'h0, 36'h0, 4'hf, 4'hf);
      chk(36'(single), 36'h1);
      for (int i = 0; i < 8; i++) step(2, 3'(i), 1'b0, 36'(xs()), 36'(~xs()), 4'h0, 4'h0);
      $display("preload done");
      // back-to-back reads then writes with split lane masks, both orders
      for (int i = 0; i < 4; i++) step(1, 3'(i), i[0], 36'h0, 36'h0, 4'h0, 4'h0);
      step(0, 3'h1, 1'b0, 36'hfffffffff, 36'h0, 4'h0, 4'h0);
      for (int i = 0; i < 4; i++)
         step(2, 3'(i), 1'b1, 36'(xs()), 36'(xs()), 4'h5 << i[0], 4'ha >> i[0]);
      for (int i = 0; i < 4; i++) step(1, 3'(i), i[1], 36'h0, 36'h0, 4'h0, 4'h0);
      $display("burst corner test done");
      dll_off_n = 1'b1;
      for (int i = 0; i < 1100; i++) begin
         op = xs() % 3;
         if (op == 2 && h[0].op == 1) op = 0;
         step(op, 3'(xs()), 1'(xs()), 36'(xs()), 36'(xs()), 4'(xs()), 4'(xs()));
         if (i == 1015) chk(36'(locked), 36'h0);
         if (i == 1035) chk(36'(locked), 36'h1);
      end
      repeat (4) step(0, 3'h0, 1'b0, 36'h0, 36'h0, 4'hf, 4'hf);
      $display("random traffic test done");
      // second reset in mid-run with the C pair running: C mode strap
      @(posedge clock_i);
      #1 rst_i = 1'b1;
      c_run = 1'b1;
      repeat (20) @(posedge clock_i);
      #1 rst_i = 1'b0;
      repeat (4) step(0, 3'h0, 1'b0, 36'h0, 36'h0, 4'hf, 4'hf);
      chk(36'(single), 36'h0);
      step(2, 3'h5, 1'b1, 36'(xs()), 36'(xs()), 4'h0, 4'h3);
      repeat (3) step(0, 3'h0, 1'b0, 36'h0, 36'h0, 4'hf, 4'hf);
      c_read(3'h5, 1'b1);
      c_read(3'h2, 1'b0);
      $display("clock pair test done");
      results();
   end
endmodule : tb
